//--- rtl/fed_map.vh
// Constants for the flow-through error detection and correction datapath.
// Assumes it is included by bare name from the design files under rtl/.
`ifndef FED_MAP_VH
`define FED_MAP_VH

// Datapath widths and queue depth.
`define FED_DW            64
`define FED_CW            8
`define FED_BW            8
`define FED_QDEPTH        16
`define FED_QAW           4

// Mode register layout and reset value.
`define FED_MODE_W        16
`define FED_MODE_LSB      0
`define FED_MODE_MSB      2
`define FED_MODE_RST      16'h0003

// Operating mode codes held in mode register bits 2..0.
`define FED_MD_ERRDATA    3'h0
`define FED_MD_DIAG       3'h1
`define FED_MD_GENDET     3'h2
`define FED_MD_NORMAL     3'h3
`define FED_MD_INJECT     3'h4

// Syndrome classes.
`define FED_CL_NONE       3'h0
`define FED_CL_DATA       3'h1
`define FED_CL_CHECK      3'h2
`define FED_CL_DOUBLE     3'h3
`define FED_CL_MULTI      3'h4

// Register bus byte offsets.
`define FED_AW            4
`define FED_OFS_MODE      4'h0
`define FED_OFS_STATUS    4'h4

// Status register field positions.
`define FED_ST_SYN_LSB    0
`define FED_ST_SYN_MSB    7
`define FED_ST_CL_LSB     8
`define FED_ST_CL_MSB     10
`define FED_ST_WEMPTY     12
`define FED_ST_WFULL      13
`define FED_ST_REMPTY     14
`define FED_ST_RFULL      15

`endif

//--- rtl/fed_queue.v
// Sixteen-deep queue used for both the write and the read buffers.
// Assumes both sides share clock_i; pushes and pops are same-clock strobes.
`timescale 1ns/1ps
`include "fed_map.vh"

module fed_queue #(
  parameter W = 72                        // Word width.
) (
  input  wire         clock_i,            // Common clock.
  input  wire         rst_n_i,            // Asynchronous reset, active low.
  input  wire         push_i,             // Push request.
  input  wire         pop_i,              // Pop request.
  input  wire [W-1:0] data_i,             // Word to store.
  output wire [W-1:0] data_o,             // Word last popped.
  output reg          full_o,             // Queue holds sixteen words.
  output reg          empty_o             // Queue holds nothing.
);

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  reg [W-1:0]          mem_ff [0:`FED_QDEPTH-1]; // Word storage.
  reg [`FED_QAW-1:0]   wr_ptr_ff;                 // Next location to write.
  reg [`FED_QAW-1:0]   rd_ptr_ff;                 // Next location to read.
  reg [`FED_QAW-1:0]   out_idx_ff;                // Location shown at output.
  reg [`FED_QAW:0]     count_ff;                  // Words held.
  reg                  primed_ff;                 // First push after reset seen.
  reg [`FED_QAW:0]     nxt_count;                 // Count after this edge.
  wire                 do_push;                   // Accepted push.
  wire                 do_pop;                    // Accepted pop.

  // Flags are registered from the next count, so leaving empty or full is
  // seen on the same edge as the accepted push or pop; no extra cycle is added.
  assign do_push = push_i & primed_ff & ~full_o;
  assign do_pop  = pop_i & ~empty_o;

  // The output keeps showing the last popped location, so the write that
  // fills the queue lands there and changes the output.
  assign data_o = mem_ff[out_idx_ff];

  // Next count from the accepted strobes.
  always @* begin
    nxt_count = count_ff;
    if (do_push & ~do_pop) begin
      nxt_count = count_ff + 5'h01;
    end else if (do_pop & ~do_push) begin
      nxt_count = count_ff - 5'h01;
    end
  end

  // Storage write; no reset so it maps to plain memory.
  always @(posedge clock_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= data_i;
    end
  end

  // Pointers, flags and the reset latency of the first push.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff  <= 4'h0;
      rd_ptr_ff  <= 4'h0;
      out_idx_ff <= 4'h0;
      count_ff   <= 5'h00;
      primed_ff  <= 1'b0;
      full_o     <= 1'b0;
      empty_o    <= 1'b1;
    end else begin
      // The first push after reset only primes the queue.
      if (push_i & ~primed_ff) begin
        primed_ff <= 1'b1;
      end
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 4'h1;
      end
      if (do_pop) begin
        out_idx_ff <= rd_ptr_ff;
        rd_ptr_ff  <= rd_ptr_ff + 4'h1;
      end
      count_ff <= nxt_count;
      full_o   <= (nxt_count == `FED_QDEPTH);
      empty_o  <= (nxt_count == 5'h00);
    end
  end

endmodule // fed_queue

//--- rtl/fed_datapath.v
// Flow-through error detection and correction datapath, 64 data bits and
// eight check bits, with byte merge, check-bit injection and two queues.
// Assumes every control input comes from logic clocked by clock_i, so the
// system and memory sides share one clock and no synchroniser is used.
//
// Functional notes
// - Writes only generate check bits, never check.
// - Bypass path captures system data while enable low.
// - Output latch loads data and checks; drives memory.
// - Check/syndrome buffer on select high or output low.
// - Write queue fills system side, drains memory side.
// - Write queue full and empty flags block access.
// - Reads take memory data and checks via latches.
// - Syndrome is regenerated xor received; normal corrects.
// - Classify: none, data bit, check bit, two, more.
// - Bypass read path latches corrected data to system.
// - Write-back uses byte lanes or queued lanes.
// - Read queue fills memory side, drains system side.
// - Read queue full and empty flags block access.
// - Flags leave empty or full on the push/pop edge.
// - First push after reset is ignored.
// - Pointers advance; fill write overwrites shown word.
// - Partial write merges bytes, then regenerates checks.
// - Injection loads check latch from system bus.
// - Config load captures system bits 15..0.
// - Zero syndrome means no error.
`timescale 1ns/1ps
`include "fed_map.vh"

module fed_datapath (
  input  wire                   clock_i,              // System clock, 50 MHz.
  input  wire                   rst_n_i,              // Asynchronous reset, active low.
  // System side.
  input  wire [`FED_DW-1:0]     sys_data_bus_i,       // System data bus level.
  output reg  [`FED_DW-1:0]     sys_data_bus_o,       // System data driven out.
  output reg  [`FED_BW-1:0]     sys_data_bus_oe_o,    // Per-byte drive enable.
  input  wire                   sys_out_en_n_i,       // System output enable, active low.
  input  wire [`FED_BW-1:0]     byte_lane_sel_i,      // Byte lanes, low takes system byte.
  input  wire                   wr_path_sel_i,        // High selects the write queue.
  input  wire                   sys_in_latch_en_n_i,  // System input latch, active low.
  input  wire                   sys_out_latch_en_i,   // System output latch enable.
  input  wire                   write_queue_push_en_i,      // Write queue push.
  input  wire                   rd_path_sel_i,        // High selects the read queue.
  input  wire                   read_queue_pop_en_n_i,     // Read queue pop, active low.
  input  wire                   cfg_load_en_n_i,      // Mode register load, active low.
  // Memory side.
  input  wire [`FED_DW-1:0]     mem_data_bus_i,       // Memory data bus level.
  output reg  [`FED_DW-1:0]     mem_data_bus_o,       // Memory data driven out.
  output reg                    mem_data_bus_oe_o,    // Memory bus drive enable.
  input  wire                   mem_out_en_n_i,       // Memory output enable, active low.
  input  wire [`FED_CW-1:0]     chk_in_bus_i,         // Check bits from memory.
  output reg  [`FED_CW-1:0]     chk_syn_bus_o,        // Check bits or syndrome out.
  output reg                    chk_syn_bus_oe_o,     // Check/syndrome drive enable.
  input  wire                   chk_syn_out_sel_i,    // Check/syndrome output select.
  input  wire                   mem_in_latch_en_i,    // Memory input latch enable.
  input  wire                   mem_out_latch_en_i,   // Memory output latch enable.
  input  wire                   write_queue_pop_en_i,       // Write queue pop.
  input  wire                   read_queue_push_en_n_i,    // Read queue push, active low.
  // Flags.
  output wire                   write_queue_full_flag_o,    // Write queue full.
  output wire                   write_queue_empty_flag_o,   // Write queue empty.
  output wire                   read_queue_full_flag_o,    // Read queue full.
  output wire                   read_queue_empty_flag_o,   // Read queue empty.
  output reg                    fault_detect_o,       // Any error detected.
  output reg                    multi_bit_fault_o,    // Two or more errors; any error in injection mode.
  // Avalon-MM slave.
  input  wire [`FED_AW-1:0]     avs_address_i,        // Byte address.
  input  wire                   avs_read_i,           // Read request.
  input  wire                   avs_write_i,          // Write request.
  input  wire [31:0]            avs_writedata_i,      // Write data.
  input  wire [3:0]             avs_byteenable_i,     // Byte enables.
  output reg  [31:0]            avs_readdata_o,       // Read data.
  output reg                    avs_waitrequest_o     // Wait request.
);

  // ------------------------------------------------------------------
  // Code functions
  // ------------------------------------------------------------------

  // Column of the check matrix for data bit idx: the idx-th eight-bit value
  // of odd weight three or more, so every single error gives a distinct
  // odd syndrome and every double error an even one.
  function [`FED_CW-1:0] fed_col;
    input integer idx;
    integer v;
    integer n;
    integer w;
    integer b;
    begin
      fed_col = 8'h00;
      n = 0;
      for (v = 0; v < 256; v = v + 1) begin
        w = 0;
        for (b = 0; b < 8; b = b + 1) begin
          w = w + ((v >> b) & 1);
        end
        if ((w >= 3) && (w % 2 == 1)) begin
          if (n == idx) begin
            fed_col = v[7:0];
          end
          n = n + 1;
        end
      end
    end
  endfunction

  // Check bits of a 64-bit word; used on both the write and read sides.
  function [`FED_CW-1:0] fed_gen;
    input [`FED_DW-1:0] d;
    integer i;
    begin
      fed_gen = 8'h00;
      for (i = 0; i < `FED_DW; i = i + 1) begin
        if (d[i]) begin
          fed_gen = fed_gen ^ fed_col(i);
        end
      end
    end
  endfunction

  // Syndrome class.
  function [2:0] fed_class;
    input [`FED_CW-1:0] s;
    integer i;
    integer w;
    begin
      w = 0;
      for (i = 0; i < `FED_CW; i = i + 1) begin
        w = w + s[i];
      end
      if (w == 0) begin
        fed_class = `FED_CL_NONE;
      end else if (w == 1) begin
        fed_class = `FED_CL_CHECK;
      end else if (w % 2 == 0) begin
        fed_class = `FED_CL_DOUBLE;
      end else begin
        fed_class = `FED_CL_MULTI;
        for (i = 0; i < `FED_DW; i = i + 1) begin
          if (s == fed_col(i)) begin
            fed_class = `FED_CL_DATA;
          end
        end
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // Registers and wires
  // ------------------------------------------------------------------
  reg  [`FED_MODE_W-1:0] mode_ff;         // Mode register.
  reg  [`FED_DW-1:0]     sys_in_ff;       // System input latch.
  reg  [`FED_DW-1:0]     md_in_ff;        // Memory data input latch.
  reg  [`FED_CW-1:0]     cb_in_ff;        // Memory check-bit latch.
  reg  [`FED_DW-1:0]     md_out_ff;       // Memory output latch (read path).
  reg  [`FED_CW-1:0]     wr_chk_ff;       // Check bits of the latched write.
  reg  [`FED_CW-1:0]     syn_ff;          // Registered syndrome.
  reg  [2:0]             class_ff;        // Registered class.
  reg  [`FED_DW-1:0]     fix_mask;        // Bit to flip for a single data error.
  reg  [`FED_DW-1:0]     merged;          // Byte-merged write word.
  wire [2:0]             mode_sel;        // Operating mode.
  wire [`FED_CW-1:0]     syn;             // Live syndrome.
  wire [2:0]             syn_class;       // Live class.
  wire [`FED_DW-1:0]     cor_data;        // Corrected or raw read data.
  wire [`FED_DW-1:0]     wr_src;          // Write source word.
  wire [`FED_BW-1:0]     wr_lanes;        // Byte lanes for the merge.
  wire [`FED_DW+`FED_BW-1:0] wq_out;      // Write queue output.
  wire [`FED_DW-1:0]     rq_out;          // Read queue output.
  wire                   bus_hit;         // Avalon request seen this cycle.

  assign mode_sel = mode_ff[`FED_MODE_MSB:`FED_MODE_LSB];

  // ------------------------------------------------------------------
  // Queues
  // ------------------------------------------------------------------

  // Write queue carries the word and its byte lanes so the lanes stay with
  // the data until the memory side drains it.
  fed_queue #(
    .W        (`FED_DW + `FED_BW)
  ) u_write_queue (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .push_i   (wr_path_sel_i & write_queue_push_en_i),
    .pop_i    (wr_path_sel_i & write_queue_pop_en_i),
    .data_i   ({byte_lane_sel_i, sys_data_bus_i}),
    .data_o   (wq_out),
    .full_o   (write_queue_full_flag_o),
    .empty_o  (write_queue_empty_flag_o)
  );

  // Read queue takes corrected data on the memory side.
  fed_queue #(
    .W        (`FED_DW)
  ) u_read_queue (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .push_i   (rd_path_sel_i & ~read_queue_push_en_n_i),
    .pop_i    (rd_path_sel_i & ~read_queue_pop_en_n_i),
    .data_i   (cor_data),
    .data_o   (rq_out),
    .full_o   (read_queue_full_flag_o),
    .empty_o  (read_queue_empty_flag_o)
  );

  // ------------------------------------------------------------------
  // Read side: syndrome, class and correction
  // ------------------------------------------------------------------

  // Regenerated checks xor received checks.
  assign syn       = fed_gen(md_in_ff) ^ cb_in_ff;
  assign syn_class = fed_class(syn);

  // Locate the single data bit in error, if any.
  always @* begin : fix_blk
    integer i;
    fix_mask = {`FED_DW{1'b0}};
    for (i = 0; i < `FED_DW; i = i + 1) begin
      fix_mask[i] = (syn == fed_col(i));
    end
  end

  // Only normal mode corrects; generate-detect passes data unchanged.
  assign cor_data = (mode_sel == `FED_MD_NORMAL) ? (md_in_ff ^ fix_mask) : md_in_ff;

  // Memory input latches. In injection mode the check-bit latch loads from
  // the system bus so a mismatch can be forced for self-test.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_in_ff <= 64'h0000000000000000;
      cb_in_ff <= 8'h00;
    end else begin
      if (mem_in_latch_en_i) begin
        md_in_ff <= mem_data_bus_i;
        if (mode_sel == `FED_MD_INJECT) begin
          cb_in_ff <= sys_data_bus_i[`FED_CW-1:0];
        end else begin
          cb_in_ff <= chk_in_bus_i;
        end
      end
    end
  end

  // Error outputs follow the live class one edge later. In injection mode
  // any mismatch raises both outputs.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn_ff            <= 8'h00;
      class_ff          <= `FED_CL_NONE;
      fault_detect_o    <= 1'b0;
      multi_bit_fault_o <= 1'b0;
    end else begin
      syn_ff         <= syn;
      class_ff       <= syn_class;
      fault_detect_o <= (syn_class != `FED_CL_NONE);
      if (mode_sel == `FED_MD_INJECT) begin
        multi_bit_fault_o <= (syn_class != `FED_CL_NONE);
      end else begin
        multi_bit_fault_o <= (syn_class == `FED_CL_DOUBLE) |
                             (syn_class == `FED_CL_MULTI);
      end
    end
  end

  // ------------------------------------------------------------------
  // Write side: source select, byte merge and check generation
  // ------------------------------------------------------------------

  // Bypass path captures system data while its enable is low.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_in_ff <= 64'h0000000000000000;
    end else if (!sys_in_latch_en_n_i) begin
      sys_in_ff <= sys_data_bus_i;
    end
  end

  // With the queue selected its stored lanes steer the merge; otherwise the
  // live lanes do. All ones selects pure write-back.
  assign wr_src   = wr_path_sel_i ? wq_out[`FED_DW-1:0] : sys_in_ff;
  assign wr_lanes = wr_path_sel_i ? wq_out[`FED_DW+`FED_BW-1:`FED_DW] : byte_lane_sel_i;

  // A low lane takes the system byte, a high lane the memory byte.
  always @* begin : merge_blk
    integer k;
    merged = {`FED_DW{1'b0}};
    for (k = 0; k < `FED_BW; k = k + 1) begin
      merged[k*8 +: 8] = wr_lanes[k] ? cor_data[k*8 +: 8] : wr_src[k*8 +: 8];
    end
  end

  // Output latch holds the word and its freshly generated check bits; no
  // checking happens on this path in any mode.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_data_bus_o <= 64'h0000000000000000;
      wr_chk_ff      <= 8'h00;
    end else if (sys_out_latch_en_i) begin
      mem_data_bus_o <= merged;
      wr_chk_ff      <= fed_gen(merged);
    end
  end

  // ------------------------------------------------------------------
  // Memory-side drivers
  // ------------------------------------------------------------------

  // The memory bus is driven while its enable is low; the check/syndrome
  // bus shows check bits then and the syndrome otherwise.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_data_bus_oe_o <= 1'b0;
      chk_syn_bus_o     <= 8'h00;
      chk_syn_bus_oe_o  <= 1'b0;
    end else begin
      mem_data_bus_oe_o <= ~mem_out_en_n_i;
      chk_syn_bus_oe_o  <= chk_syn_out_sel_i | ~mem_out_en_n_i;
      chk_syn_bus_o     <= mem_out_en_n_i ? syn_ff : wr_chk_ff;
    end
  end

  // ------------------------------------------------------------------
  // System-side read output
  // ------------------------------------------------------------------

  // Bypass read path latches corrected data while its enable is high.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_out_ff <= 64'h0000000000000000;
    end else if (mem_out_latch_en_i) begin
      md_out_ff <= cor_data;
    end
  end

  // A byte is driven when the output enable is low and its lane is high.
  // The host keeps these off during writes; nothing here enforces it.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_data_bus_o    <= 64'h0000000000000000;
      sys_data_bus_oe_o <= 8'h00;
    end else begin
      sys_data_bus_o    <= rd_path_sel_i ? rq_out : md_out_ff;
      sys_data_bus_oe_o <= {`FED_BW{~sys_out_en_n_i}} & byte_lane_sel_i;
    end
  end

  // ------------------------------------------------------------------
  // Mode register and Avalon-MM slave
  // ------------------------------------------------------------------

  // One request is answered per two cycles: waitrequest drops for one
  // cycle after the request is seen, which keeps the read mux off the
  // critical path at the cost of a fixed wait state.
  assign bus_hit = (avs_read_i | avs_write_i) & avs_waitrequest_o;

  // The pin load wins over a bus write in the same cycle, since it is the
  // documented way to configure the datapath.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= `FED_MODE_RST;
    end else if (!cfg_load_en_n_i) begin
      mode_ff <= sys_data_bus_i[`FED_MODE_W-1:0];
    end else if (avs_write_i & ~avs_waitrequest_o & (avs_address_i == `FED_OFS_MODE)) begin
      if (avs_byteenable_i[0]) begin
        mode_ff[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        mode_ff[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // Handshake and read data; unmapped reads return zero, unmapped writes
  // are dropped.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~bus_hit;
      if (bus_hit & avs_read_i) begin
        case (avs_address_i)
          `FED_OFS_MODE: begin
            avs_readdata_o <= {16'h0000, mode_ff};
          end
          `FED_OFS_STATUS: begin
            avs_readdata_o <= {16'h0000, read_queue_full_flag_o, read_queue_empty_flag_o,
                               write_queue_full_flag_o, write_queue_empty_flag_o, 1'b0, class_ff, syn_ff};
          end
          default: begin
            avs_readdata_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // fed_datapath

//--- testbench/fed_chk_asserts.sv
// Checker of enable timing, queue flags and fault outputs.
// Assumes it is bound to fed_datapath, everything on clock_i.
`timescale 1ns/1ps
module fed_chk (
  input logic       clock_i, rst_n_i, sys_out_en_n_i, mem_out_en_n_i, chk_syn_out_sel_i,
  input logic       write_queue_push_en_i, read_queue_push_en_n_i, chk_syn_bus_oe_o, mem_data_bus_oe_o,
  input logic       write_queue_full_flag_o, write_queue_empty_flag_o, read_queue_full_flag_o, read_queue_empty_flag_o,
  input logic       fault_detect_o, multi_bit_fault_o,
  input logic [7:0] byte_lane_sel_i, sys_data_bus_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // The $past guards skip the first edge after reset, which still sees reset-time inputs.
  // The enable is replicated so a high output enable clears every lane.
  property p_soe;
    $past(rst_n_i) |-> sys_data_bus_oe_o == $past({8{!sys_out_en_n_i}} & byte_lane_sel_i);
  endproperty
  a_soe: assert property (p_soe) else $error("sys oe");
  property p_cbe;
    $past(rst_n_i) |-> chk_syn_bus_oe_o == ($past(chk_syn_out_sel_i) | !$past(mem_out_en_n_i));
  endproperty
  a_cbe: assert property (p_cbe) else $error("chk oe");
  property p_mde; $past(rst_n_i) |-> mem_data_bus_oe_o == !$past(mem_out_en_n_i); endproperty
  a_mde: assert property (p_mde) else $error("mem oe");
  property p_wfl; write_queue_full_flag_o |-> !write_queue_empty_flag_o; endproperty
  a_wfl: assert property (p_wfl) else $error("wq flags");
  property p_rfl; read_queue_full_flag_o |-> !read_queue_empty_flag_o; endproperty
  a_rfl: assert property (p_rfl) else $error("rq flags");
  property p_mlt; multi_bit_fault_o |-> fault_detect_o; endproperty
  a_mlt: assert property (p_mlt) else $error("multi");
  property p_wem; write_queue_empty_flag_o && !write_queue_push_en_i |=> write_queue_empty_flag_o; endproperty
  a_wem: assert property (p_wem) else $error("wq empty");
  property p_rem; read_queue_empty_flag_o && read_queue_push_en_n_i |=> read_queue_empty_flag_o; endproperty
  a_rem: assert property (p_rem) else $error("rq empty");
endmodule // fed_chk
bind fed_datapath fed_chk u_chk (.*);

//--- testbench/fed_mem_model.sv
// Memory array model: one location of data and check bits.
// Assumes the bench ties it to the datapath's memory side.
`timescale 1ns/1ps
module fed_mem_model (
  input  logic        clock_i, we_i,
  input  logic [63:0] wd_i, flip_i,
  input  logic [7:0]  wc_i,
  output logic [63:0] md_o = 64'h0,
  output logic [7:0]  cb_o = 8'h0
);
  // Stores the written word, corrupted by flip_i on command.
  always @(posedge clock_i) begin
    if (we_i) begin
      md_o <= wd_i ^ flip_i;
      cb_o <= wc_i;
    end
  end
endmodule // fed_mem_model

//--- testbench/tb_top.sv
// Bench: write/read with injected errors, queues, registers.
// Assumes the memory model on the far side and a 50 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic        clock_i = 0, rst_n_i = 0, soe_n = 1, wps = 0, sile_n = 1, sole = 0, wpush = 0, rps = 0;
  logic        rpop_n = 1, cfg_n = 1, moe_n = 1, mile = 0, mole = 0, wpop = 0, rpush_n = 1, rd = 0, wr = 0, cbs = 0;
  logic        mdoe, cboe, wf, we, rf, re, flt, mlt, wt;
  logic [63:0] sd = 0, md, sdo, mdo, mm, flip = 0;
  logic [7:0]  bls = 0, sdoe, cbo, mc;
  logic [3:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  int          fails = 0, check_count = 0;
  assign md = mdoe ? mdo : mm; // The datapath wins while it drives.
  initial forever #10 clock_i = ~clock_i;
  fed_mem_model MEM (.clock_i, .we_i(mdoe & !moe_n), .wd_i(mdo), .flip_i(flip), .wc_i(cbo), .md_o(mm), .cb_o(mc));
  fed_datapath DUT (.clock_i, .rst_n_i, .sys_data_bus_i(sd), .sys_data_bus_o(sdo), .sys_data_bus_oe_o(sdoe),
    .sys_out_en_n_i(soe_n), .byte_lane_sel_i(bls), .wr_path_sel_i(wps), .sys_in_latch_en_n_i(sile_n),
    .sys_out_latch_en_i(sole), .write_queue_push_en_i(wpush), .rd_path_sel_i(rps), .read_queue_pop_en_n_i(rpop_n),
    .cfg_load_en_n_i(cfg_n), .mem_data_bus_i(md), .mem_data_bus_o(mdo), .mem_data_bus_oe_o(mdoe),
    .mem_out_en_n_i(moe_n), .chk_in_bus_i(mc), .chk_syn_bus_o(cbo), .chk_syn_bus_oe_o(cboe),
    .chk_syn_out_sel_i(cbs), .mem_in_latch_en_i(mile), .mem_out_latch_en_i(mole), .write_queue_pop_en_i(wpop),
    .read_queue_push_en_n_i(rpush_n), .write_queue_full_flag_o(wf), .write_queue_empty_flag_o(we), .read_queue_full_flag_o(rf),
    .read_queue_empty_flag_o(re), .fault_detect_o(flt), .multi_bit_fault_o(mlt), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt));
  task chk(input logic [63:0] s, e, input string n);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low; the watchdog bounds the wait.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {wr, rd, adr, wdat} <= {w, !w, a, d};
    do @(posedge clock_i); while (wt !== 1'b0);
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask
  // Check bits: data bit i uses the i-th odd-weight (three or more) byte value.
  function automatic logic [7:0] gen(input logic [63:0] d);
    int i;
    gen = 0;
    i = 0;
    for (int v = 7; v < 256; v++) if ($countones(v[7:0]) % 2 && $countones(v[7:0]) > 2 && i < 64) begin
      gen ^= d[i] ? v[7:0] : 8'h00;
      i++;
    end
  endfunction
  // Writes a random word through the bypass path, then reads it back.
  task rt(input logic [63:0] f, input logic cor);
    logic [63:0] d;
    d = {$urandom, $urandom};
    {sd, sile_n, sole, bls, moe_n, flip} <= {d, 1'b0, 1'b1, 8'h00, 1'b0, f};
    cbs <= 1'($urandom);
    repeat (4) @(posedge clock_i);
    chk(mdo, d, "mem data");
    chk(cbo, gen(d), "check bits");
    {sile_n, sole, moe_n, mile, mole, bls, soe_n} <= {3'b101, 2'b11, 8'hFF, 1'b0};
    // The first latch edge still sees the datapath's own drive, so the stored word lands one edge later.
    repeat (5) @(posedge clock_i);
    chk(flt, f != 0, "fault");
    chk(mlt, $countones(f) > 1, "multi");
    if ($countones(f) < 2) chk(sdo, cor ? d : d ^ f, "sys data");
    {mile, mole, soe_n} <= 3'b001;
  endtask
  initial begin
    void'($urandom(65));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1;
    bus(0, 4'h0, 0);
    chk(q[15:0], 16'h0003, "mode reset");
    bus(0, 4'h8, 0);
    chk(q, 0, "unmapped");
    for (int k = 0; k < 3; k++) rt((k == 0 ? 64'h0 : (k == 1 ? 64'h1 : 64'h3)) << ($urandom % 62), 1);
    bus(1, 4'h0, 32'h2);
    bus(0, 4'h0, 0);
    chk(q[15:0], 16'h0002, "mode write");
    rt(64'h1 << ($urandom % 64), 0);
    {sd, cfg_n} <= {64'h3, 1'b0};
    @(posedge clock_i);
    cfg_n <= 1;
    bus(0, 4'h0, 0);
    chk(q[15:0], 16'h0003, "mode load");
    // Injected checks one data column off: only injection makes that a multiple fault.
    bus(1, 4'h0, 32'h4);
    {sd, mile} <= {56'h0, gen(mm) ^ 8'h07, 1'b1};
    repeat (3) @(posedge clock_i);
    chk({flt, mlt}, 2'b11, "inject");
    mile <= 0;
    {wps, rps, wpush, rpush_n} <= 4'b1110;
    for (int i = 1; i <= 17; i++) begin
      @(posedge clock_i);
      #1;
      if (i == 1) chk({we, re}, 2'b11, "primed empty");
      if (i == 16) chk({wf, rf}, 2'b00, "early full");
    end
    chk({wf, rf}, 2'b11, "full");
    // One more edge of pushing while full must be refused, or the drain below ends short.
    @(posedge clock_i);
    {wpush, rpush_n, wpop, rpop_n} <= 4'b0110;
    repeat (16) @(posedge clock_i);
    #1;
    chk({we, re, wf, rf}, 4'b1100, "drained");
    @(posedge clock_i);
    {wpop, rpop_n} <= 2'b01;
    conclude;
  end
  initial begin
    #100000;
    fails++;
    conclude;
  end
endmodule // tb_top
